// [rtl/uart_ctl_defs.svh]
// register indices, field positions, reset values and timing counts
// included by the design and the bench; definitions only
`ifndef UART_CTL_DEFS_SVH
`define UART_CTL_DEFS_SVH
// register indices; byte address is four times the index
`define IDX_POWER_CONTROL 8'h87
`define IDX_SERIAL_CONTROL 8'h98
`define IDX_SERIAL_DATA 8'h99
`define IDX_GEN_RELOAD 8'h9A
`define IDX_GEN_CONTROL 8'h9B
`define IDX_STATION_ADDRESS 8'hA9
`define IDX_STATION_MASK 8'hB9
`define IDX_TIMER2_CONTROL 8'hC8
// serial_control fields
`define BIT_MODE_HI 7
`define BIT_MODE_LO 6
`define BIT_MP_EN 5
`define BIT_RX_EN 4
`define BIT_TX_NINTH 3
`define BIT_RX_NINTH 2
`define BIT_TX_DONE 1
`define BIT_RX_DONE 0
// power_control_reg fields
`define BIT_DOUBLE_BAUD 7
`define BIT_FE_ACCESS 6
`define MASK_POWER 8'hC0
// gen_control_reg fields
`define BIT_GEN_RUN 4
`define BIT_TX_GEN 3
`define BIT_RX_GEN 2
`define BIT_GEN_FAST 1
`define BIT_M0_GEN 0
`define MASK_GEN_CONTROL 8'h1F
// timer2_control_reg fields
`define BIT_RX_T2 5
`define BIT_TX_T2 4
`define MASK_TIMER2 8'h30
// reset value of every register
`define RST_REG8 8'h00
// modes
`define MODE_SHIFT 2'h0
`define MODE_UART8 2'h1
`define MODE_UART9_FIXED 2'h2
// timing counts
`define GEN_SLOW_LAST 3'h5
`define M0_DIV_LAST 3'h2
`define OVS_LAST 4'hF
`define SAMPLE_POINT 4'h7
`define TX_STOP_8 4'h9
`define TX_STOP_9 4'hA
`define RX_STOP_8 4'h8
`define RX_STOP_9 4'h9
`define RX_LAST_DATA_9 4'h8
`define M0_BITS 4'h8
`endif

// [rtl/uart_ctl_pkg.sv]
// types shared by the serial control block and its bench
// assumes nothing beyond the defs header
package uart_ctl_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_SYNC} rx_state_t;
  typedef struct packed {
    logic [11:0] paddr;
    logic pwrite;
    logic [31:0] pwdata;
    logic psel;
    logic penable;
  } apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;
  typedef struct packed {
    logic txd;
    logic rxd_out;
    logic rxd_oe;
  } serial_pins_t;
  typedef struct packed {
    logic [7:0] serial_control;
    logic frame_error_flag;
    logic [7:0] station_address;
    logic [7:0] station_mask;
    logic [7:0] gen_reload_value;
    logic [7:0] gen_control_reg;
    logic [7:0] power_control_reg;
    logic [7:0] timer2_control_reg;
    logic [7:0] gen_cnt;
    logic [2:0] gen_div;
    logic [2:0] m0_div;
    logic [1:0] tx_pre;
    logic [1:0] rx_pre;
    tx_state_t tx_state;
    logic [3:0] tx_sub;
    logic [3:0] tx_bitn;
    logic [10:0] tx_shift;
    rx_state_t rx_state;
    logic [3:0] rx_sub;
    logic [3:0] rx_bitn;
    logic [8:0] rx_shift;
    logic [7:0] rx_buf;
    logic rxd_prev;
    logic m0_phase;
    logic [31:0] prdata;
    serial_pins_t pins;
  } ctl_state_t;
endpackage

// [rtl/uart_clock_select_and_control.sv]
// serial port: bit clock selection, rate generator, control register,
// station address matching, transmitter and receiver
// assumes timer overflows arrive as one-cycle pulses on pclk
`timescale 1ns/1ps
`include "uart_ctl_defs.svh"
`default_nettype none

module uart_clock_select_and_control (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // register bus
  input wire uart_ctl_pkg::apb_req_t req,
  output uart_ctl_pkg::apb_rsp_t rsp,
  // timer overflow pulses
  input wire logic timer1_ovf,
  input wire logic timer2_ovf,
  // serial line
  input wire logic rxd_in,
  output uart_ctl_pkg::serial_pins_t pins
);
  import uart_ctl_pkg::*;

  ctl_state_t s;
  ctl_state_t n;

  function automatic logic hit(logic [11:0] a, logic [7:0] idx);
    return (a[11:10] == 2'h0) && (a[1:0] == 2'h0) && (a[9:2] == idx);
  endfunction

  // source pulse for one direction
  function automatic logic src_pulse(logic m2, logic gsel, logic t2sel,
                                     logic g, logic t1, logic t2);
    return m2 ? 1'b1 : (gsel ? g : (t2sel ? t2 : t1));
  endfunction

  // last prescale count before a 16x sample tick
  function automatic logic [1:0] src_last(logic m2, logic gsel,
                                          logic t2sel, logic dbl);
    if (m2 || (!gsel && !t2sel)) begin
      return dbl ? 2'h0 : 2'h1;
    end
    if (gsel) begin
      return dbl ? 2'h1 : 2'h3;
    end
    return 2'h0;
  endfunction

  function automatic logic addr_match(logic [7:0] b, logic [7:0] a,
                                      logic [7:0] m);
    logic [7:0] bc;
    bc = a | m;
    return (((b ^ a) & m) == 8'h00) || (((b ^ bc) & bc) == 8'h00);
  endfunction

  logic [1:0] mode;
  logic is_m0;
  logic is_m1;
  logic is_m2;
  logic dbl;
  logic [7:0] wb;
  logic wr;
  logic any_hit;
  logic [7:0] ctl_rd;
  logic [7:0] rd_data;
  logic gen_step;
  logic gen_ovf;
  logic m0_tick;
  logic tx_raw;
  logic rx_raw;
  logic tx_st;
  logic rx_st;
  logic [3:0] tx_stop;
  logic [3:0] rx_stop;
  logic rx_early;
  logic [7:0] fin_byte;
  logic fin_ninth;
  logic fin_stop_ok;
  logic fin_accept;

  assign mode = {s.serial_control[`BIT_MODE_HI],
                 s.serial_control[`BIT_MODE_LO]};
  assign is_m0 = (mode == `MODE_SHIFT);
  assign is_m1 = (mode == `MODE_UART8);
  assign is_m2 = (mode == `MODE_UART9_FIXED);
  assign dbl = s.power_control_reg[`BIT_DOUBLE_BAUD];
  assign wb = req.pwdata[7:0];
  assign wr = req.psel && req.penable && req.pwrite;

  // register read path
  assign ctl_rd = {s.power_control_reg[`BIT_FE_ACCESS] ?
                   s.frame_error_flag : s.serial_control[`BIT_MODE_HI],
                   s.serial_control[6:0]};
  assign rd_data =
    hit(req.paddr, `IDX_SERIAL_CONTROL) ? ctl_rd :
    hit(req.paddr, `IDX_SERIAL_DATA) ? s.rx_buf :
    hit(req.paddr, `IDX_POWER_CONTROL) ? s.power_control_reg :
    hit(req.paddr, `IDX_GEN_RELOAD) ? s.gen_reload_value :
    hit(req.paddr, `IDX_GEN_CONTROL) ? s.gen_control_reg :
    hit(req.paddr, `IDX_STATION_ADDRESS) ? s.station_address :
    hit(req.paddr, `IDX_STATION_MASK) ? s.station_mask :
    hit(req.paddr, `IDX_TIMER2_CONTROL) ? s.timer2_control_reg : 8'h00;
  assign any_hit = hit(req.paddr, `IDX_SERIAL_CONTROL) ||
    hit(req.paddr, `IDX_SERIAL_DATA) || hit(req.paddr, `IDX_POWER_CONTROL) ||
    hit(req.paddr, `IDX_GEN_RELOAD) || hit(req.paddr, `IDX_GEN_CONTROL) ||
    hit(req.paddr, `IDX_STATION_ADDRESS) ||
    hit(req.paddr, `IDX_STATION_MASK) ||
    hit(req.paddr, `IDX_TIMER2_CONTROL);
  assign rsp.prdata = s.prdata;
  assign rsp.pready = 1'b1;
  assign rsp.pslverr = req.psel && req.penable && !any_hit;
  assign pins = s.pins;

  // internal rate generator
  assign gen_step = s.gen_control_reg[`BIT_GEN_RUN] &&
    (s.gen_control_reg[`BIT_GEN_FAST] ||
     (s.gen_div == `GEN_SLOW_LAST));
  assign gen_ovf = gen_step && (s.gen_cnt == 8'hFF);

  // mode 0 half-bit tick: clk/3 or generator overflow
  assign m0_tick = s.gen_control_reg[`BIT_M0_GEN] ? gen_ovf :
                   (s.m0_div == `M0_DIV_LAST);

  // 16x sample ticks per direction
  assign tx_raw = src_pulse(is_m2, s.gen_control_reg[`BIT_TX_GEN],
                            s.timer2_control_reg[`BIT_TX_T2], gen_ovf,
                            timer1_ovf, timer2_ovf);
  assign rx_raw = src_pulse(is_m2, s.gen_control_reg[`BIT_RX_GEN],
                            s.timer2_control_reg[`BIT_RX_T2], gen_ovf,
                            timer1_ovf, timer2_ovf);
  assign tx_st = tx_raw && (s.tx_pre == src_last(is_m2,
    s.gen_control_reg[`BIT_TX_GEN], s.timer2_control_reg[`BIT_TX_T2],
    dbl));
  assign rx_st = rx_raw && (s.rx_pre == src_last(is_m2,
    s.gen_control_reg[`BIT_RX_GEN], s.timer2_control_reg[`BIT_RX_T2],
    dbl));

  assign tx_stop = is_m1 ? `TX_STOP_8 : `TX_STOP_9;
  assign rx_stop = is_m1 ? `RX_STOP_8 : `RX_STOP_9;
  // without frame checking, 9-bit frames end at the ninth bit
  assign rx_early = !is_m1 && !s.power_control_reg[`BIT_FE_ACCESS] &&
                    (s.rx_bitn == `RX_LAST_DATA_9);

  // frame result at the final sample
  assign fin_byte = (!is_m1 && s.rx_bitn == `RX_STOP_9) ?
                    s.rx_shift[7:0] : s.rx_shift[8:1];
  assign fin_ninth = (!is_m1 && s.rx_bitn == `RX_STOP_9) ?
                     s.rx_shift[8] : rxd_in;
  assign fin_stop_ok = (s.rx_bitn == rx_stop) ? rxd_in : 1'b1;
  assign fin_accept = !s.serial_control[`BIT_RX_DONE] &&
    (!s.serial_control[`BIT_MP_EN] || (fin_ninth &&
     addr_match(fin_byte, s.station_address,
                s.station_mask)));

  always_comb begin
    n = s;
    n.rxd_prev = rxd_in;
    if (req.psel && !req.penable) begin
      n.prdata = {24'h000000, rd_data};
    end

    // software writes first so hardware sets below win
    if (wr) begin
      if (hit(req.paddr, `IDX_SERIAL_CONTROL)) begin
        n.serial_control = wb;
        if (s.power_control_reg[`BIT_FE_ACCESS]) begin
          n.serial_control[`BIT_MODE_HI] = s.serial_control[`BIT_MODE_HI];
          n.frame_error_flag = wb[`BIT_MODE_HI];
        end
      end
      if (hit(req.paddr, `IDX_POWER_CONTROL)) begin
        n.power_control_reg = wb & `MASK_POWER;
      end
      if (hit(req.paddr, `IDX_GEN_RELOAD)) begin
        n.gen_reload_value = wb;
      end
      if (hit(req.paddr, `IDX_GEN_CONTROL)) begin
        n.gen_control_reg = wb & `MASK_GEN_CONTROL;
      end
      if (hit(req.paddr, `IDX_STATION_ADDRESS)) begin
        n.station_address = wb;
      end
      if (hit(req.paddr, `IDX_STATION_MASK)) begin
        n.station_mask = wb;
      end
      if (hit(req.paddr, `IDX_TIMER2_CONTROL)) begin
        n.timer2_control_reg = wb & `MASK_TIMER2;
      end
      if (hit(req.paddr, `IDX_SERIAL_DATA) && s.tx_state == TX_IDLE &&
          s.rx_state != RX_SYNC) begin
        n.tx_sub = 4'h0;
        n.tx_bitn = 4'h0;
        n.m0_phase = 1'b0;
        if (is_m0) begin
          n.tx_state = TX_SYNC;
          n.tx_shift = {3'h7, wb};
        end else begin
          n.tx_state = TX_ASYNC;
          n.tx_shift = {1'b1, is_m1 ? 1'b1 :
                        s.serial_control[`BIT_TX_NINTH],
                        wb, 1'b0};
        end
      end
    end

    // generator and dividers
    if (!s.gen_control_reg[`BIT_GEN_RUN]) begin
      n.gen_cnt = s.gen_reload_value;
      n.gen_div = 3'h0;
    end else begin
      n.gen_div = (s.gen_div == `GEN_SLOW_LAST) ? 3'h0 : s.gen_div + 3'h1;
      if (gen_step) begin
        n.gen_cnt = gen_ovf ? s.gen_reload_value :
                    s.gen_cnt + 8'h01;
      end
    end
    n.m0_div = (s.m0_div == `M0_DIV_LAST) ? 3'h0 : s.m0_div + 3'h1;
    if (tx_raw) begin
      n.tx_pre = tx_st ? 2'h0 : s.tx_pre + 2'h1;
    end
    if (rx_raw) begin
      n.rx_pre = rx_st ? 2'h0 : s.rx_pre + 2'h1;
    end

    // transmitter
    case (s.tx_state)
      TX_IDLE: begin
      end
      TX_ASYNC: begin
        if (tx_st) begin
          n.tx_sub = s.tx_sub + 4'h1;
          if (s.tx_sub == `OVS_LAST) begin
            if (s.tx_bitn == tx_stop) begin
              n.tx_state = TX_IDLE;
            end else begin
              n.tx_shift = {1'b1, s.tx_shift[10:1]};
              n.tx_bitn = s.tx_bitn + 4'h1;
              if (s.tx_bitn + 4'h1 == tx_stop) begin
                n.serial_control[`BIT_TX_DONE] = 1'b1;
              end
            end
          end
        end
      end
      TX_SYNC: begin
        if (m0_tick) begin
          n.m0_phase = !s.m0_phase;
          if (s.m0_phase) begin
            n.tx_shift = {1'b1, s.tx_shift[10:1]};
            n.tx_bitn = s.tx_bitn + 4'h1;
            if (s.tx_bitn + 4'h1 == `M0_BITS) begin
              n.tx_state = TX_IDLE;
              n.serial_control[`BIT_TX_DONE] = 1'b1;
            end
          end
        end
      end
      default: n.tx_state = TX_IDLE;
    endcase

    // receiver
    if (!s.serial_control[`BIT_RX_EN]) begin
      n.rx_state = RX_IDLE;
    end else begin
      case (s.rx_state)
        RX_IDLE: begin
          if (is_m0) begin
            if (!s.serial_control[`BIT_RX_DONE] &&
                s.tx_state == TX_IDLE) begin
              n.rx_state = RX_SYNC;
              n.rx_bitn = 4'h0;
              n.m0_phase = 1'b0;
            end
          end else if (s.rxd_prev && !rxd_in) begin
            n.rx_state = RX_START;
            n.rx_sub = 4'h0;
          end
        end
        RX_START, RX_DATA: begin
          if (rx_st) begin
            n.rx_sub = s.rx_sub + 4'h1;
            if (s.rx_sub == `SAMPLE_POINT) begin
              if (s.rx_state == RX_START) begin
                n.rx_state = rxd_in ? RX_IDLE : RX_DATA;
                n.rx_bitn = 4'h0;
              end else begin
                if (s.rx_bitn != rx_stop) begin
                  n.rx_shift = {rxd_in, s.rx_shift[8:1]};
                end
                n.rx_bitn = s.rx_bitn + 4'h1;
                if (s.rx_bitn == rx_stop || rx_early) begin
                  n.rx_state = RX_IDLE;
                  if (!fin_stop_ok) begin
                    n.frame_error_flag = 1'b1;
                  end
                  if (fin_accept) begin
                    n.rx_buf = fin_byte;
                    n.serial_control[`BIT_RX_NINTH] = fin_ninth;
                    n.serial_control[`BIT_RX_DONE] = 1'b1;
                  end
                end
              end
            end
          end
        end
        RX_SYNC: begin
          if (m0_tick) begin
            n.m0_phase = !s.m0_phase;
            if (!s.m0_phase) begin
              n.rx_shift = {1'b0, rxd_in, s.rx_shift[7:1]};
              n.rx_bitn = s.rx_bitn + 4'h1;
            end else if (s.rx_bitn == `M0_BITS) begin
              n.rx_state = RX_IDLE;
              n.rx_buf = s.rx_shift[7:0];
              n.serial_control[`BIT_RX_DONE] = 1'b1;
            end
          end
        end
        default: n.rx_state = RX_IDLE;
      endcase
    end

    // pins: mode 0 drives the shift clock on txd, and data on the rxd pin only while transmitting
    n.pins.rxd_oe = (n.tx_state == TX_SYNC);
    n.pins.rxd_out = n.tx_shift[0];
    if (n.tx_state == TX_SYNC || n.rx_state == RX_SYNC) begin
      n.pins.txd = n.m0_phase;
    end else if (n.tx_state == TX_ASYNC) begin
      n.pins.txd = n.tx_shift[0];
    end else begin
      n.pins.txd = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.pins.txd <= 1'b1;
      s.rxd_prev <= 1'b1;
    end else begin
      s <= n;
    end
  end
endmodule

`default_nettype wire

// [test/uart_ctl_assertions.sv]
// port assertions for the serial control block
// bound into every instance of the block; sees its ports only
`timescale 1ns/1ps
`default_nettype none
module uart_ctl_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // register bus
  input wire uart_ctl_pkg::apb_req_t req,
  input wire uart_ctl_pkg::apb_rsp_t rsp,
  // timers and serial line
  input wire logic timer1_ovf,
  input wire logic timer2_ovf,
  input wire logic rxd_in,
  input wire uart_ctl_pkg::serial_pins_t pins
);
  import uart_ctl_pkg::*;
  logic mapped;
  logic access;
  logic setup;
  always_comb begin
    case (req.paddr)
      12'h21C, 12'h260, 12'h264, 12'h268, 12'h26C, 12'h2A4, 12'h2E4,
      12'h320: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign access = req.psel && req.penable;
  assign setup = req.psel && !req.penable;
  logic dat_wr;
  assign dat_wr = access && req.pwrite && (req.paddr == 12'h264);
  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_bad_setup;
    setup && !req.pwrite && !mapped;
  endsequence
  sequence s_access;
    access;
  endsequence
  property p_ready;
    rsp.pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err_idle;
    !access |-> !rsp.pslverr;
  endproperty
  a_err_idle: assert property (p_err_idle) else $error("stray pslverr");
  property p_err_unmapped;
    access && !mapped |-> rsp.pslverr;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped)
    else $error("unmapped access without pslverr");
  property p_err_mapped;
    access && mapped |-> !rsp.pslverr;
  endproperty
  a_err_mapped: assert property (p_err_mapped)
    else $error("pslverr on mapped register");
  property p_upper_zero;
    rsp.prdata[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("prdata upper bits set");
  property p_data_hold;
    !setup |=> $stable(rsp.prdata);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("prdata moved outside setup");
  property p_unmapped_zero;
    s_bad_setup ##1 s_access |-> rsp.prdata == 32'h00000000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");
  property p_reset_idle;
    $rose(presetn) |-> rsp.prdata == 32'h00000000 && pins.txd
      && !pins.rxd_oe;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("outputs not idle after reset");
  property p_oe_after_write;
    $rose(pins.rxd_oe) |-> $past(dat_wr);
  endproperty
  a_oe_after_write: assert property (p_oe_after_write)
    else $error("drive enable without data write");
endmodule
bind uart_clock_select_and_control uart_ctl_checker i_checker (
  .pclk(pclk), .presetn(presetn), .req(req), .rsp(rsp),
  .timer1_ovf(timer1_ovf), .timer2_ovf(timer2_ovf), .rxd_in(rxd_in),
  .pins(pins)
);
`default_nettype wire

// [test/serial_node.sv]
// remote serial node: drives the receive line, captures txd frames
// assumes calls start just after a rising pclk edge
`timescale 1ns/1ps
`default_nettype none
module serial_node (
  // clock
  input wire logic pclk,
  // serial line
  input wire logic txd,
  output logic line_out
);
  initial line_out = 1'b1;
  // start bit, then n bits lsb first; line idles high
  task automatic send(input int bitc, input logic [10:0] bits,
    input int n);
    line_out <= 1'b0;
    repeat (bitc) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      line_out <= bits[i];
      repeat (bitc) @(posedge pclk);
    end
    line_out <= 1'b1;
  endtask
  // mode 0: next bit after each falling shift clock
  task automatic shift_in(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(negedge txd);
      line_out <= d[i];
    end
    @(posedge txd);
    line_out <= 1'b1;
  endtask
  // samples mid bit after the start edge
  task automatic recv(input int bitc, input int n,
    output logic [10:0] bits);
    bits = 11'h000;
    @(negedge txd);
    repeat (bitc / 2) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      repeat (bitc) @(posedge pclk);
      bits[i] = txd;
    end
  endtask
endmodule
`default_nettype wire

// [test/uart_clock_select_and_control_test.sv]
// bench for the serial control block: apb tasks and frame checks
// assumes the node model and the checker are compiled first
`timescale 1ns/1ps
`include "uart_ctl_defs.svh"
`default_nettype none
module uart_clock_select_and_control_test;
  import uart_ctl_pkg::*;
  localparam logic [11:0] A_SC = {2'b00, `IDX_SERIAL_CONTROL, 2'b00};
  localparam logic [11:0] A_DAT = {2'b00, `IDX_SERIAL_DATA, 2'b00};
  localparam logic [11:0] A_PWR = {2'b00, `IDX_POWER_CONTROL, 2'b00};
  localparam logic [11:0] A_GEN = {2'b00, `IDX_GEN_CONTROL, 2'b00};
  localparam logic [11:0] A_RLD = {2'b00, `IDX_GEN_RELOAD, 2'b00};
  localparam logic [11:0] A_T2 = {2'b00, `IDX_TIMER2_CONTROL, 2'b00};
  localparam logic [11:0] A_SA = {2'b00, `IDX_STATION_ADDRESS, 2'b00};
  localparam logic [11:0] A_SM = {2'b00, `IDX_STATION_MASK, 2'b00};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  logic timer1_ovf = 1'b0;
  logic timer2_ovf = 1'b0;
  logic line;
  serial_pins_t pins;
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  logic [31:0] rv;
  logic err;
  logic [10:0] fr;
  logic [11:0] regs [3] = '{A_SC, A_SA, A_SM};
  logic [7:0] adr [4] = '{8'h57, 8'h12, 8'hFF, 8'h54};
  logic nin [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
  logic hit [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  uart_clock_select_and_control i_dut (.pclk(pclk), .presetn(presetn),
    .req(req), .rsp(rsp), .timer1_ovf(timer1_ovf),
    .timer2_ovf(timer2_ovf), .rxd_in(line), .pins(pins));
  serial_node i_node (.pclk(pclk), .txd(pins.txd), .line_out(line));
  initial begin
    forever #5 pclk = ~pclk;
  end
  task automatic print_verdict;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // timer overflows every 2 and every 3 cycles; hang limit
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    timer1_ovf <= (cyc % 2 == 0);
    timer2_ovf <= (cyc % 3 == 0);
    if (cyc == 40000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic cmp(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w,
    input logic [7:0] d);
    req <= '{a, w, {24'h000000, d}, 1'b1, 1'b0};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    rv = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(a, 1'b0, 8'h00);
  endtask
  // mode 1 frame of 0x55; d1 to d3 falls span two bits
  task automatic txrate(input logic [7:0] t2, input logic [7:0] gen,
    input logic [7:0] rld, input logic [7:0] pwr, input int bitc);
    time t0;
    wr(A_T2, t2);
    wr(A_RLD, rld);
    wr(A_GEN, gen);
    wr(A_PWR, pwr);
    wr(A_SC, 8'h40);
    wr(A_DAT, 8'h55);
    @(negedge pins.txd);
    t0 = $time;
    @(negedge pins.txd);
    cmp("bit time", 32'(bitc * 20), 32'($time - t0));
    repeat (bitc * 5 - 4) @(posedge pclk);
    rd(A_SC);
    cmp("tx done early", 32'h40, rv);
    repeat (4) @(posedge pclk);
    rd(A_SC);
    cmp("tx done", 32'h42, rv);
    repeat (bitc) @(posedge pclk);
    wr(A_SC, 8'h40);
  endtask
  task automatic rxf(input int bitc, input logic [10:0] bits, input int n);
    i_node.send(bitc, bits, n);
    repeat (20) @(posedge pclk);
    rd(A_SC);
  endtask
  initial begin
    time t0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (regs[k]) begin
      rd(regs[k]);
      cmp("reset value", 32'h0, rv);
    end
    wr(A_SA, 8'hA5);
    rd(A_SA);
    cmp("station address", 32'hA5, rv);
    wr(A_SM, 8'h3C);
    rd(A_SM);
    cmp("station mask", 32'h3C, rv);
    wr(12'h100, 8'hFF);
    cmp("slverr", 32'h1, {31'h0, err});
    rd(12'h100);
    cmp("unmapped read", 32'h0, rv);
    txrate(8'h00, 8'h00, 8'h00, 8'h00, 64);
    txrate(8'h10, 8'h00, 8'h00, 8'h00, 48);
    txrate(8'h20, 8'h14, 8'hFE, 8'h00, 64);
    txrate(8'h10, 8'h1A, 8'hFE, 8'h00, 128);
    txrate(8'h00, 8'h1A, 8'hFE, 8'h80, 64);
    txrate(8'h00, 8'h18, 8'hFF, 8'h00, 384);
    wr(A_T2, 8'h20);
    wr(A_GEN, 8'h00);
    wr(A_SC, 8'h50);
    rxf(48, {2'b00, 1'b1, 8'hC6}, 9);
    cmp("control", 32'h55, rv);
    rd(A_DAT);
    cmp("data", 32'hC6, rv);
    wr(A_PWR, 8'h80);
    for (int i = 0; i < 2; i++) begin
      wr(A_SC, (i == 0) ? 8'h88 : 8'h80);
      fork
        i_node.recv(16, 10, fr);
        wr(A_DAT, 8'hA3);
      join
      cmp("frame", 32'({1'b1, (i == 0), 8'hA3}), {22'h0, fr[9:0]});
      rd(A_SC);
      cmp("tx done", 32'h1, {31'h0, rv[1]});
      repeat (16) @(posedge pclk);
    end
    wr(A_SC, 8'h90);
    rxf(16, {2'b01, 9'h15A}, 10);
    cmp("control", 32'h95, rv);
    rd(A_DAT);
    cmp("data", 32'h5A, rv);
    wr(A_SC, 8'h90);
    rxf(16, {2'b01, 9'h05A}, 10);
    cmp("control", 32'h91, rv);
    wr(A_SC, 8'h80);
    rxf(16, {2'b01, 9'h15A}, 10);
    cmp("control", 32'h80, rv);
    wr(A_PWR, 8'hC0);
    wr(A_SC, 8'h10);
    rd(A_SC);
    cmp("control", 32'h10, rv);
    rxf(16, {2'b00, 9'h15A}, 10);
    cmp("frame error", 32'h1, {31'h0, rv[7]});
    wr(A_SC, 8'h90);
    rxf(16, {2'b01, 9'h15A}, 10);
    cmp("frame error", 32'h1, {31'h0, rv[7]});
    wr(A_SC, 8'h10);
    rd(A_SC);
    cmp("control", 32'h10, rv);
    wr(A_SA, 8'h56);
    wr(A_SM, 8'hFC);
    foreach (adr[k]) begin
      wr(A_SC, 8'h30);
      rxf(16, {2'b01, nin[k], adr[k]}, 10);
      cmp("address flag", {31'h0, hit[k]}, {31'h0, rv[0]});
    end
    wr(A_PWR, 8'h00);
    for (int i = 0; i < 2; i++) begin
      wr(A_GEN, (i == 0) ? 8'h00 : 8'h11);
      wr(A_SC, 8'h00);
      wr(A_DAT, 8'h96);
      @(negedge pins.txd);
      t0 = $time;
      @(negedge pins.txd);
      cmp("period", (i == 0) ? 32'h3C : 32'h78, 32'($time - t0));
      cmp("drive enable", 32'h1, {31'h0, pins.rxd_oe});
      @(negedge pins.txd);
      cmp("shift data", 32'h0, {31'h0, pins.rxd_out});
      repeat (120) @(posedge pclk);
      rd(A_SC);
      cmp("control", 32'h02, rv);
    end
    fork
      i_node.shift_in(8'h1D);
      wr(A_SC, 8'h10);
    join
    repeat (20) @(posedge pclk);
    rd(A_SC);
    cmp("control", 32'h11, rv);
    rd(A_DAT);
    cmp("data", 32'h1D, rv);
    print_verdict();
  end
endmodule
`default_nettype wire
